// >>> sffc_line_partner.sv
// sffc_line_partner: serial line device facing the transmit and receive pins
// assumes bit times are handed in by the caller, counted in system clocks
`default_nettype none

module sffc_line_partner (
  input  wire logic sys_clk,
  input  wire logic txdOut,
  input  wire logic serClkOut,
  output var  logic rxdIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // the line rests high until a character is sent
  initial rxdIn = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // wait for a start bit, then sample n bits in mid bit
  task automatic capture(input int n, input int bitLen, output logic [15:0] f);
    int k;
    f = '1;
    k = 0;
    while (txdOut !== 1'b0 && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (bitLen / 2) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txdOut;
      repeat (bitLen) @(negedge sys_clk);
    end
  endtask : capture

  // clocked mode: take the data line on each rising serial clock
  task automatic syncCapture(input int n, output logic [15:0] f);
    f = '1;
    for (int i = 0; i < n; i++) begin
      @(posedge serClkOut);
      f[i] = txdOut;
    end
  endtask : syncCapture

  // drive n bits, first bit first, each held bitLen clocks
  task automatic send(input logic [15:0] f, input int n, input int bitLen);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rxdIn <= f[i];
      repeat (bitLen - 1) @(posedge sys_clk);
    end
  endtask : send

endmodule : sffc_line_partner

`default_nettype wire

// >>> sffc_pkg.sv
// sffc_pkg: constants, register layout and carrier types of the serial frame format block
// assumes one system clock; all offsets are word indices on the plain register port
`default_nettype none

package sffc_pkg;

  // register offsets on the plain port
  localparam logic [2:0] OFS_MODE   = 3'h0; // serial_format_mode
  localparam logic [2:0] OFS_BITDIV = 3'h1; // bit time divisor
  localparam logic [2:0] OFS_TXDATA = 3'h2; // transmit byte, write starts a frame
  localparam logic [2:0] OFS_RXDATA = 3'h3; // received byte, read clears valid
  localparam logic [2:0] OFS_STATUS = 3'h4; // status, write 1 clears error flags
  localparam logic [2:0] OFS_MPCTL  = 3'h5; // multi node bit sent with next frame

  // reset values
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] BITDIV_RST = 8'hFF;
  localparam logic [7:0] RXDATA_RST = 8'h00;

  // status field positions
  localparam int ST_TXBUSY  = 0;
  localparam int ST_RXVALID = 1;
  localparam int ST_PARERR  = 2;
  localparam int ST_FRMERR  = 3;
  localparam int ST_RXMP    = 4;

  // clock select codes and prescaler width
  localparam logic [1:0] CKS_DIV1  = 2'h0;
  localparam logic [1:0] CKS_DIV4  = 2'h1;
  localparam logic [1:0] CKS_DIV16 = 2'h2;
  localparam logic [1:0] CKS_DIV64 = 2'h3;
  localparam int         PRE_W     = 6;

  // last data bit index for eight and seven bit characters
  localparam logic [2:0] LAST_BIT8 = 3'h7;
  localparam logic [2:0] LAST_BIT7 = 3'h6;

  // mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       syncMode;          // 1 clocked synchronous, 0 asynchronous
    logic       char_length_select; // 1 seven data bits
    logic       parity_enable;     // 1 parity added and checked
    logic       parityOdd;         // 1 odd, 0 even
    logic       stopTwo;           // 1 two stop bits
    logic       multi_node_format; // 1 multi node frame
    logic       baud_clock_select_hi;
    logic       baud_clock_select_lo;
  } sffc_mode_t;

  // register port request
  typedef struct packed {
    logic       wr;    // write strobe
    logic       rd;    // read strobe
    logic [2:0] addr;  // word offset
    logic [7:0] wdata; // write data
  } sffc_busreq_t;

  // frame sequencer states, gray along start-data-parity-multi node-stop1-stop2
  typedef enum logic [2:0] {
    FR_IDLE  = 3'b000,
    FR_START = 3'b001,
    FR_DATA  = 3'b011,
    FR_PAR   = 3'b010,
    FR_MPB   = 3'b110,
    FR_STOP1 = 3'b111,
    FR_STOP2 = 3'b101
  } sffc_frame_t;

  // parity used only in asynchronous, non multi node frames
  function automatic logic sffcParOn(input sffc_mode_t m);
    return !m.syncMode && m.parity_enable && !m.multi_node_format;
  endfunction : sffcParOn

  // multi node bit present only in asynchronous frames
  function automatic logic sffcMpOn(input sffc_mode_t m);
    return !m.syncMode && m.multi_node_format;
  endfunction : sffcMpOn

  // index of the last data bit; synchronous is always eight bits
  function automatic logic [2:0] sffcLast(input sffc_mode_t m);
    return (!m.syncMode && m.char_length_select) ? LAST_BIT7 : LAST_BIT8;
  endfunction : sffcLast

endpackage : sffc_pkg

`default_nettype wire

// >>> sffc_top.sv
// sffc_top: mode register, prescaler and frame sequencer of one serial channel
// assumes rxdIn is an asynchronous pin; busReq and standby come from sys_clk logic
//
// What this block does
// - eight-bit mode register cleared by reset, standby
// - mode register readable and writable except during reset, standby
// - bit 7 picks asynchronous or synchronous
// - bit 6 picks seven bits, async only
// - seven-bit characters never send data bit 7
// - bit 5 enables async parity add and check
// - synchronous mode has no parity at all
// - sense 0 gives even ones count
// - sense 1 gives odd ones count
// - sense ignored when parity unused
// - bit 3 sends one or two stop bits
// - synchronous frames carry no stop bits
// - receiver checks only the first stop bit
// - low after first stop starts next character
// - multi node format overrides parity settings
// - multi node format only in async mode
// - bits 1:0 pick divide by 1,4,16,64
// - characters travel least significant bit first
//
// The register offsets and the address-and-strobe port were decided locally.
`default_nettype none

module sffc_top
  import sffc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic         standby,
  input  wire sffc_busreq_t busReq,
  output var  logic [7:0]   rdata,
  input  wire logic         rxdIn,
  output var  logic         txdOut,
  output var  logic         serClkOut
);

  ////////////////////////////////////////////////////////////////
  // state of the whole block
  typedef struct packed {
    sffc_mode_t  modeQ;   // serial_format_mode
    logic [7:0]  bitDivQ; // ticks per bit minus one
    logic [PRE_W-1:0] preQ; // free running prescaler
    logic        mpCtlQ;  // multi node bit for next frame
    logic [7:0]  rdataQ;  // read data, one cycle only
    sffc_frame_t txStQ;   // transmit sequencer
    sffc_mode_t  txFrmQ;  // format latched for this frame
    logic [7:0]  txByteQ; // byte being sent
    logic [2:0]  txIdxQ;  // data bit index
    logic [7:0]  txCntQ;  // ticks within bit
    logic        txMpQ;   // multi node bit of this frame
    logic        txdQ;    // line level
    logic        sclkQ;   // synchronous clock out
    sffc_frame_t rxStQ;   // receive sequencer
    sffc_mode_t  rxFrmQ;  // format latched for this frame
    logic [7:0]  rxByteQ; // byte being assembled
    logic [2:0]  rxIdxQ;  // data bit index
    logic [7:0]  rxCntQ;  // ticks within bit
    logic        rxPbadQ; // parity mismatch this frame
    logic [7:0]  rxDataQ; // last received byte
    logic        rxValidQ;
    logic        rxMpQ;   // multi node bit received
    logic        parErrQ;
    logic        frmErrQ;
    logic        s1Q;     // pin synchroniser stages
    logic        s2Q;
    logic        s3Q;
    logic        rxLvlQ;  // filtered line level
  } sffc_state_t;

  sffc_state_t s_q; // registered state
  sffc_state_t s_d; // next state

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic       tick;    // prescaled baud tick
    logic       txEnd;   // last tick of a transmit bit
    logic       rxEnd;   // sample point of a receive bit
    logic [7:0] rxTgt;   // ticks to the sample point
    logic [7:0] txMask;  // byte with bit 7 cut for seven bits
    logic [7:0] stat;    // status image
    tick   = 1'b0;
    txEnd  = 1'b0;
    rxEnd  = 1'b0;
    rxTgt  = 8'h00;
    txMask = 8'h00;
    stat   = 8'h00;
    s_d    = s_q;
    s_d.rdataQ = 8'h00;
    // three stage pin filter; level moves when stages two and three agree
    s_d.s1Q = rxdIn;
    s_d.s2Q = s_q.s1Q;
    s_d.s3Q = s_q.s2Q;
    if (s_q.s2Q == s_q.s3Q) begin
      s_d.rxLvlQ = s_q.s3Q;
    end
    // prescaler and clock select
    s_d.preQ = s_q.preQ + PRE_W'(1);
    case ({s_q.modeQ.baud_clock_select_hi, s_q.modeQ.baud_clock_select_lo})
      CKS_DIV1:  tick = 1'b1;
      CKS_DIV4:  tick = (s_q.preQ[1:0] == 2'h0);
      CKS_DIV16: tick = (s_q.preQ[3:0] == 4'h0);
      CKS_DIV64: tick = (s_q.preQ[5:0] == 6'h00);
      default:   tick = 1'b0;
    endcase
    stat[ST_TXBUSY]  = (s_q.txStQ != FR_IDLE);
    stat[ST_RXVALID] = s_q.rxValidQ;
    stat[ST_PARERR]  = s_q.parErrQ;
    stat[ST_FRMERR]  = s_q.frmErrQ;
    stat[ST_RXMP]    = s_q.rxMpQ;
    // register reads, data stands in the next cycle only
    if (busReq.rd) begin
      case (busReq.addr)
        OFS_MODE:   s_d.rdataQ = s_q.modeQ;
        OFS_BITDIV: s_d.rdataQ = s_q.bitDivQ;
        OFS_TXDATA: s_d.rdataQ = s_q.txByteQ;
        OFS_RXDATA: begin
          s_d.rdataQ   = s_q.rxDataQ;
          s_d.rxValidQ = 1'b0;
        end
        OFS_STATUS: s_d.rdataQ = stat;
        OFS_MPCTL:  s_d.rdataQ = {7'h00, s_q.mpCtlQ};
        default:    s_d.rdataQ = 8'h00;
      endcase
    end
    // register writes; error flags clear on a one
    if (busReq.wr) begin
      case (busReq.addr)
        OFS_MODE:   s_d.modeQ = busReq.wdata;
        OFS_BITDIV: s_d.bitDivQ = busReq.wdata;
        OFS_STATUS: begin
          if (busReq.wdata[ST_PARERR]) s_d.parErrQ = 1'b0;
          if (busReq.wdata[ST_FRMERR]) s_d.frmErrQ = 1'b0;
        end
        OFS_MPCTL:  s_d.mpCtlQ = busReq.wdata[0];
        default:    ;
      endcase
    end
    ////////////////////////////////////////////////////////////////
    // transmit sequencer; bit time is bitDiv+1 ticks
    txEnd = tick && (s_q.txCntQ == s_q.bitDivQ);
    if (s_q.txStQ != FR_IDLE && tick) begin
      s_d.txCntQ = txEnd ? 8'h00 : s_q.txCntQ + 8'h01;
    end
    txMask = s_q.txFrmQ.syncMode ? s_q.txByteQ
           : {s_q.txByteQ[7] & !s_q.txFrmQ.char_length_select, s_q.txByteQ[6:0]};
    case (s_q.txStQ)
      FR_IDLE: begin
        // a write while busy is dropped; busy shows in status
        if (busReq.wr && busReq.addr == OFS_TXDATA) begin
          s_d.txFrmQ  = s_q.modeQ;
          s_d.txByteQ = busReq.wdata;
          s_d.txIdxQ  = 3'h0;
          s_d.txCntQ  = 8'h00;
          s_d.txMpQ   = s_q.mpCtlQ;
          if (s_q.modeQ.syncMode) begin
            s_d.txStQ = FR_DATA;
            s_d.txdQ  = busReq.wdata[0];
            s_d.sclkQ = 1'b0;
          end else begin
            s_d.txStQ = FR_START;
            s_d.txdQ  = 1'b0;
          end
        end
      end
      FR_START: begin
        if (txEnd) begin
          s_d.txStQ = FR_DATA;
          s_d.txdQ  = s_q.txByteQ[0];
        end
      end
      FR_DATA: begin
        // synchronous clock rises mid bit; partner samples there
        if (s_q.txFrmQ.syncMode && tick && s_q.txCntQ == {1'b0, s_q.bitDivQ[7:1]}) begin
          s_d.sclkQ = 1'b1;
          s_d.rxByteQ[s_q.txIdxQ] = s_q.rxLvlQ;
        end
        if (txEnd) begin
          if (s_q.txIdxQ == sffcLast(s_q.txFrmQ)) begin
            if (s_q.txFrmQ.syncMode) begin
              // no parity, no stop bit; the received byte lands now
              s_d.txStQ    = FR_IDLE;
              s_d.txdQ     = 1'b1;
              s_d.sclkQ    = 1'b1;
              s_d.rxDataQ  = s_q.rxByteQ;
              s_d.rxValidQ = 1'b1;
            end else if (sffcParOn(s_q.txFrmQ)) begin
              s_d.txStQ = FR_PAR;
              s_d.txdQ  = (^txMask) ^ s_q.txFrmQ.parityOdd;
            end else if (sffcMpOn(s_q.txFrmQ)) begin
              s_d.txStQ = FR_MPB;
              s_d.txdQ  = s_q.txMpQ;
            end else begin
              s_d.txStQ = FR_STOP1;
              s_d.txdQ  = 1'b1;
            end
          end else begin
            s_d.txIdxQ = s_q.txIdxQ + 3'h1;
            s_d.txdQ   = s_q.txByteQ[s_q.txIdxQ + 3'h1];
            s_d.sclkQ  = !s_q.txFrmQ.syncMode;
          end
        end
      end
      FR_PAR, FR_MPB: begin
        if (txEnd) begin
          s_d.txStQ = FR_STOP1;
          s_d.txdQ  = 1'b1;
        end
      end
      FR_STOP1: begin
        if (txEnd) begin
          s_d.txStQ = s_q.txFrmQ.stopTwo ? FR_STOP2 : FR_IDLE;
        end
      end
      FR_STOP2: begin
        if (txEnd) begin
          s_d.txStQ = FR_IDLE;
        end
      end
      default: s_d.txStQ = FR_IDLE;
    endcase
    ////////////////////////////////////////////////////////////////
    // asynchronous receive sequencer; start bit sampled at half bit
    rxTgt = (s_q.rxStQ == FR_START) ? {1'b0, s_q.bitDivQ[7:1]} : s_q.bitDivQ;
    rxEnd = tick && (s_q.rxCntQ == rxTgt);
    if (s_q.rxStQ != FR_IDLE && tick) begin
      s_d.rxCntQ = rxEnd ? 8'h00 : s_q.rxCntQ + 8'h01;
    end
    case (s_q.rxStQ)
      FR_IDLE: begin
        if (!s_q.modeQ.syncMode && !s_q.rxLvlQ) begin
          s_d.rxStQ   = FR_START;
          s_d.rxFrmQ  = s_q.modeQ;
          s_d.rxByteQ = 8'h00;
          s_d.rxIdxQ  = 3'h0;
          s_d.rxCntQ  = 8'h00;
          s_d.rxPbadQ = 1'b0;
        end
      end
      FR_START: begin
        // a high level at mid start bit was a glitch
        if (rxEnd) begin
          s_d.rxStQ = s_q.rxLvlQ ? FR_IDLE : FR_DATA;
        end
      end
      FR_DATA: begin
        if (rxEnd) begin
          s_d.rxByteQ[s_q.rxIdxQ] = s_q.rxLvlQ;
          s_d.rxIdxQ = s_q.rxIdxQ + 3'h1;
          if (s_q.rxIdxQ == sffcLast(s_q.rxFrmQ)) begin
            if (sffcParOn(s_q.rxFrmQ)) begin
              s_d.rxStQ = FR_PAR;
            end else if (sffcMpOn(s_q.rxFrmQ)) begin
              s_d.rxStQ = FR_MPB;
            end else begin
              s_d.rxStQ = FR_STOP1;
            end
          end
        end
      end
      FR_PAR: begin
        if (rxEnd) begin
          s_d.rxPbadQ = (^{s_q.rxByteQ, s_q.rxLvlQ}) != s_q.rxFrmQ.parityOdd;
          s_d.rxStQ   = FR_STOP1;
        end
      end
      FR_MPB: begin
        if (rxEnd) begin
          s_d.rxMpQ = s_q.rxLvlQ;
          s_d.rxStQ = FR_STOP1;
        end
      end
      FR_STOP1: begin
        // only this stop bit is checked; the sequencer rearms at once
        if (rxEnd) begin
          s_d.rxStQ    = FR_IDLE;
          s_d.rxDataQ  = s_q.rxByteQ;
          s_d.rxValidQ = 1'b1;
          if (s_q.rxPbadQ) s_d.parErrQ = 1'b1;
          if (!s_q.rxLvlQ) s_d.frmErrQ = 1'b1;
        end
      end
      default: s_d.rxStQ = FR_IDLE;
    endcase
    // reset and standby clear everything except the divisor and the line levels, which go to ones
    if (srst || standby) begin
      s_d         = '0;
      s_d.modeQ   = MODE_RST;
      s_d.bitDivQ = BITDIV_RST;
      s_d.rxDataQ = RXDATA_RST;
      s_d.txdQ    = 1'b1;
      s_d.sclkQ   = 1'b1;
      s_d.s1Q     = 1'b1;
      s_d.s2Q     = 1'b1;
      s_d.s3Q     = 1'b1;
      s_d.rxLvlQ  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  // outputs straight from flops
  assign rdata     = s_q.rdataQ;
  assign txdOut    = s_q.txdQ;
  assign serClkOut = s_q.sclkQ;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // helper for the stop check: transmit sequencer state changes this cycle
  logic txEnd_w;
  assign txEnd_w = (s_q.txStQ != s_d.txStQ);

  // first stop bit is high in the single cycle matched
  sequence stopHigh;
    (s_q.txStQ == FR_STOP1 && s_q.txdQ) [*1];
  endsequence

  chk_mode_clear: assert property (standby |=> s_q.modeQ == MODE_RST)
    else $error("mode register not cleared by standby");
  chk_mode_write: assert property (busReq.wr && busReq.addr == OFS_MODE && !standby
      |=> s_q.modeQ == $past(busReq.wdata))
    else $error("mode register write lost");
  chk_mode_read: assert property (busReq.rd && busReq.addr == OFS_MODE
      |=> rdata == $past(s_q.modeQ) ##1 ($past(busReq.rd) || rdata == 8'h00))
    else $error("mode read data wrong or held");
  chk_start_low: assert property ($rose(s_q.txStQ == FR_START) |-> !txdOut && !s_q.txFrmQ.syncMode)
    else $error("start bit not low");
  chk_lsb_first: assert property ($rose(s_q.txStQ == FR_DATA) |-> txdOut == s_q.txByteQ[0])
    else $error("first data bit not bit 0");
  chk_data_last: assert property (s_q.txStQ == FR_DATA && s_d.txStQ != FR_DATA && !standby
      |-> s_q.txIdxQ == ((!s_q.txFrmQ.syncMode && s_q.txFrmQ.char_length_select) ? 3'h6 : 3'h7))
    else $error("wrong character length");
  chk_sync_bare: assert property (s_q.txStQ != FR_IDLE && s_q.txFrmQ.syncMode
      |-> s_q.txStQ == FR_DATA)
    else $error("sync frame has framing bits");
  chk_par_even: assert property (s_q.txStQ == FR_PAR && !s_q.txFrmQ.parityOdd
      |-> ^{txdOut, s_q.txByteQ[6:0], s_q.txByteQ[7] & !s_q.txFrmQ.char_length_select} == 1'b0)
    else $error("even parity wrong");
  chk_par_odd: assert property (s_q.txStQ == FR_PAR && s_q.txFrmQ.parityOdd
      |-> ^{txdOut, s_q.txByteQ[6:0], s_q.txByteQ[7] & !s_q.txFrmQ.char_length_select} == 1'b1)
    else $error("odd parity wrong");
  chk_mp_nopar: assert property (s_q.txStQ == FR_PAR |-> !s_q.txFrmQ.multi_node_format)
    else $error("parity sent in multi node frame");
  chk_stop_count: assert property (stopHigh ##0 (s_q.txStQ == FR_STOP1 && txEnd_w && !s_q.txFrmQ.stopTwo)
      |=> s_q.txStQ == FR_IDLE)
    else $error("extra stop bit");
  chk_rx_onestop: assert property (s_q.rxStQ == FR_STOP1 && s_d.rxStQ != FR_STOP1
      |=> s_q.rxStQ == FR_IDLE)
    else $error("receiver waited for second stop");
  chk_div64: assert property (s_q.modeQ[1:0] == CKS_DIV64 && s_q.txStQ == FR_STOP1 && s_d.txStQ == FR_STOP2
      |-> s_q.preQ[5:0] == 6'h00)
    else $error("prescaler tick off");

endmodule : sffc_top

`default_nettype wire

// >>> test_serial_frame_format_config.sv
// test_serial_frame_format_config: self-checking bench of the frame format block
// assumes the line partner model beside the block and a 200 MHz clock
`default_nettype none

`define SFFC_CHK(got, exp) \
  samplesChecked++; \
  if ((got) !== (exp)) begin \
    badCount++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
  end

module test_serial_frame_format_config
  import sffc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BL = 4; // clocks per bit with divisor 3 at full rate

  logic         sys_clk;
  logic         srst;
  logic         standby = 1'b0;
  sffc_busreq_t busReq  = '0;
  logic [7:0]   rdata;
  logic         rxdIn;
  logic         txdOut;
  logic         serClkOut;
  int           badCount = 0;
  int           samplesChecked = 0;
  int           cyc = 0;

  sffc_top DUT (.sys_clk(sys_clk), .srst(srst), .standby(standby), .busReq(busReq),
    .rdata(rdata), .rxdIn(rxdIn), .txdOut(txdOut), .serClkOut(serClkOut));

  sffc_line_partner partner (.sys_clk(sys_clk), .txdOut(txdOut),
    .serClkOut(serClkOut), .rxdIn(rxdIn));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // closing report and hang guard
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : reportAndStop

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      reportAndStop();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    busReq <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    busReq <= '0;
    @(negedge sys_clk);
    d = rdata;
  endtask : rd

  // poll until the transmitter is idle
  task automatic waitIdle();
    logic [7:0] s = 8'h01;
    for (int k = 0; k < 400 && s[ST_TXBUSY] !== 1'b0; k++) rd(OFS_STATUS, s);
    `SFFC_CHK(s[ST_TXBUSY], 1'b0)
  endtask : waitIdle

  // expected asynchronous frame from mode bits, plus one idle bit
  function automatic int build(input logic [7:0] m, input logic [7:0] d, input logic mpb,
                               output logic [15:0] f);
    logic q[$];
    logic p;
    p = m[4];
    f = '1;
    q.push_back(1'b0);
    for (int i = 0; i < (m[6] ? 7 : 8); i++) begin
      q.push_back(d[i]);
      p = p ^ d[i];
    end
    if (m[2]) q.push_back(mpb);
    else if (m[5]) q.push_back(p);
    q.push_back(1'b1);
    if (m[3]) q.push_back(1'b1);
    q.push_back(1'b1);
    foreach (q[i]) f[i] = q[i];
    return q.size();
  endfunction : build

  ////////////////////////////////////////////////////////////////////////
  // reset value, read back, unmapped offset, standby clear
  task automatic testRegs();
    logic [7:0] v;
    logic [7:0] pat [3] = '{8'hFF, 8'h5A, 8'hA5};
    rd(OFS_MODE, v);
    `SFFC_CHK(v, MODE_RST)
    foreach (pat[i]) begin
      wr(OFS_MODE, pat[i]);
      rd(OFS_MODE, v);
      `SFFC_CHK(v, pat[i])
    end
    wr(3'h6, 8'h77);
    rd(3'h6, v);
    `SFFC_CHK(v, 8'h00)
    @(posedge sys_clk);
    standby <= 1'b1;
    @(posedge sys_clk);
    standby <= 1'b0;
    rd(OFS_MODE, v);
    `SFFC_CHK(v, 8'h00)
    $display("register test done");
  endtask : testRegs

  // one transmitted frame against the expected bit list
  task automatic txCase(input logic [7:0] m, input logic [7:0] d, input logic mpb);
    logic [15:0] e;
    logic [15:0] f;
    int          n;
    n = build(m, d, mpb, e);
    wr(OFS_MODE, m);
    wr(OFS_MPCTL, {7'h00, mpb});
    fork
      partner.capture(n, BL, f);
      wr(OFS_TXDATA, d);
    join
    `SFFC_CHK(f, e)
    waitIdle();
  endtask : txCase

  task automatic testTx();
    wr(OFS_BITDIV, 8'h03);
    txCase(8'h00, 8'hA6, 1'b0);
    txCase(8'h20, 8'h07, 1'b0);
    txCase(8'h30, 8'h07, 1'b0);
    txCase(8'h10, 8'hC3, 1'b0);
    txCase(8'h48, 8'hB5, 1'b0);
    txCase(8'h60, 8'hFF, 1'b0);
    txCase(8'h34, 8'h5E, 1'b1);
    txCase(8'h0C, 8'h81, 1'b0);
    $display("transmit format test done");
  endtask : testTx

  // width of data bit 0 of byte 01 at divisor 0 for each prescale
  task automatic testClockSel();
    int w;
    wr(OFS_BITDIV, 8'h00);
    for (int sel = 0; sel < 4; sel++) begin
      // two stop bits so the divide by 64 stop step is exercised too
      wr(OFS_MODE, 8'h08 | 8'(sel));
      w = 0;
      fork
        begin
          while (txdOut !== 1'b0 && w < 300) begin
            @(negedge sys_clk);
            w++;
          end
          while (txdOut !== 1'b1 && w < 600) @(negedge sys_clk);
          w = 0;
          while (txdOut === 1'b1 && w < 200) begin
            @(negedge sys_clk);
            w++;
          end
        end
        wr(OFS_TXDATA, 8'h01);
      join
      `SFFC_CHK(w, 1 << (2 * sel))
      waitIdle();
    end
    $display("clock select test done");
  endtask : testClockSel

  // clocked mode ignores length, parity, stop and multi node bits
  task automatic testSync();
    logic [15:0] f;
    logic [7:0]  s;
    wr(OFS_BITDIV, 8'h03);
    wr(OFS_MODE, 8'hEC);
    fork
      partner.syncCapture(8, f);
      wr(OFS_TXDATA, 8'hA5);
    join
    `SFFC_CHK(f[7:0], 8'hA5)
    repeat (BL) @(posedge sys_clk);
    rd(OFS_STATUS, s);
    `SFFC_CHK(s[ST_TXBUSY], 1'b0)
    `SFFC_CHK(serClkOut, 1'b1)
    $display("synchronous test done");
  endtask : testSync

  // status {frame error, parity error, valid} and data after a frame
  task automatic rxCheck(input logic [2:0] st, input logic [7:0] d);
    logic [7:0] s;
    logic [7:0] v;
    repeat (2 * BL) @(posedge sys_clk);
    rd(OFS_STATUS, s);
    `SFFC_CHK(s[ST_FRMERR:ST_RXVALID], st)
    if (st[0]) begin
      rd(OFS_RXDATA, v);
      `SFFC_CHK(v, d)
    end
    wr(OFS_STATUS, 8'h0C);
  endtask : rxCheck

  task automatic rxCase(input logic [7:0] m, input logic [7:0] bm, input logic [7:0] d,
                        input int flip, input logic [2:0] st);
    logic [15:0] e;
    int          n;
    wr(OFS_MODE, m);
    n = build(bm, d, 1'b0, e);
    if (flip >= 0) e[flip] = ~e[flip];
    partner.send(e, n, BL);
    rxCheck(st, d);
  endtask : rxCase

  task automatic testRx();
    logic [15:0] e;
    int          n;
    rxCase(8'h20, 8'h20, 8'h3C, -1, 3'h1);
    rxCase(8'h20, 8'h20, 8'h3C, 9, 3'h3);
    rxCase(8'h30, 8'h30, 8'hC5, -1, 3'h1);
    rxCase(8'h10, 8'h10, 8'h96, -1, 3'h1);
    rxCase(8'h00, 8'h00, 8'h5A, 9, 3'h5);
    rxCase(8'h80, 8'h00, 8'h3C, -1, 3'h0);
    wr(OFS_MODE, 8'h48);
    n = build(8'h40, 8'h11, 1'b0, e);
    partner.send(e, n - 1, BL);
    n = build(8'h40, 8'hAA, 1'b0, e);
    partner.send(e, n, BL);
    rxCheck(3'h1, 8'h2A);
    $display("receive test done");
  endtask : testRx

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    srst = 1'b1;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    testRegs();
    testTx();
    testClockSel();
    testSync();
    testRx();
    reportAndStop();
  end

endmodule : test_serial_frame_format_config

`default_nettype wire
